/* File: logic/omcs_pkg.sv */
// Constants, states and the state record of the optical module control block.
package omcs_pkg;

    // ************************************************************
    // Serial bus addresses and the control/status byte layout
    // ************************************************************
    localparam logic [7:0] OMCS_ID_ADDR = 8'hA0;
    localparam logic [7:0] OMCS_DIAG_ADDR = 8'hA2;
    localparam logic [7:0] OMCS_TEST_ADDR = 8'hB0;
    localparam logic [7:0] OMCS_CTRL_OFS = 8'h6E;
    localparam int OMCS_DEV_SEL_BIT = 1;
    localparam int OMCS_PIN_BIT = 7;
    localparam int OMCS_SOFT_BIT = 6;
    localparam int OMCS_FAULT_BIT = 2;
    localparam int OMCS_LOS_BIT = 1;
    localparam logic [3:0] OMCS_BYTE_BITS = 4'h8;
    localparam logic [3:0] OMCS_FIRST_BIT = 4'h1;
    localparam logic [7:0] OMCS_PTR_STEP = 8'h01;
    localparam logic [3:0] OMCS_CNT_STEP = 4'h1;
    localparam int OMCS_MEM_DEPTH = 256;

    // ************************************************************
    // Serial bus states and the whole register state of the block
    // ************************************************************
    typedef enum logic [2:0]
    {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_RX,
        S_TX,
        S_MACK
    } omcs_state_t;

    typedef struct packed
    {
        omcs_state_t st;
        logic scl_q;
        logic sda_q;
        logic pin_q;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic dev;
        logic rw;
        logic first;
        logic nack;
        logic drv;
        logic soft_dis;
        logic fault;
        logic laser_en;
        logic los;
    } omcs_regs_t;

endpackage

/* File: logic/omcs_ctrl.sv */
// Control, status and serial memory logic of the optical module.
// Summary of operation
// RULE1: Answer bus address A0 with identification memory.
// RULE2: Answer bus address A2 with diagnostic memory.
// RULE3: Address B0 is reserved; no answer given.
// RULE4: Transmit-off pin high stops the transmitter.
// RULE5: Undriven transmit-off counts as asserted.
// RULE6: Host spaces transmit-off assertions by 10 ms.
// RULE7: Software disable bit ORed with the pin.
// RULE8: Byte 110 bit 7 shows the pin.
// RULE9: Laser fault disables laser, asserts fault output.
// RULE10: Fault output open collector, high means fault.
// RULE11: Fault latched until transmit-off toggles or power-up.
// RULE12: Toggling transmit-off clears the fault state.
// RULE13: Byte 110 bit 2 shows the fault.
// RULE14: Unsafe optical output disables the transmitter.
// RULE15: Signal-lost output high for unusable input.
// RULE16: Byte 110 bit 1 shows signal lost.
// RULE17: Unused transmit-off line is tied to ground.
// RULE18: Status bits read-only, bit 6 read-write.
`timescale 1ns/1ps
`default_nettype none

module omcs_ctrl
    import omcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic tx_disable_i,
    input wire logic laser_fault_i,
    input wire logic unsafe_optical_i,
    input wire logic rx_signal_bad_i,
    output logic laser_enable_o,
    output logic fault_o,
    output logic fault_oe_n_o,
    output logic receive_signal_lost_o
);

    // ************************************************************
    // State, memories and decoded bus events
    // ************************************************************
    omcs_regs_t s;
    omcs_regs_t next_s;
    logic [7:0] id_mem [OMCS_MEM_DEPTH];
    logic [7:0] diag_mem [OMCS_MEM_DEPTH];
    logic mem_we;
    logic [7:0] rd_byte;
    logic [7:0] status;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic pin_rise;
    logic addr_hit;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus edges come from one sample of the pins, which are synchronous.
    assign scl_rise = scl_i & ~s.scl_q;
    assign scl_fall = ~scl_i & s.scl_q;
    assign start_c = scl_i & s.scl_q & s.sda_q & ~sda_i;
    assign stop_c = scl_i & s.scl_q & ~s.sda_q & sda_i;
    assign pin_rise = tx_disable_i & ~s.pin_q;
    // Only the two memory addresses are answered; B0 and all else are not.
    assign addr_hit = (s.shreg[7:1] == OMCS_ID_ADDR[7:1]) || // [RULE1]
                      (s.shreg[7:1] == OMCS_DIAG_ADDR[7:1]); // [RULE2] [RULE3]

    // Status byte: live images, software can only change the disable bit.
    always_comb
    begin
        status = 8'h00;
        status[OMCS_PIN_BIT] = tx_disable_i; // [RULE8] [RULE18]
        status[OMCS_SOFT_BIT] = s.soft_dis; // [RULE18]
        status[OMCS_FAULT_BIT] = s.fault; // [RULE13]
        status[OMCS_LOS_BIT] = s.los; // [RULE16]
    end

    // Read data of the selected memory, with the status byte overlaid.
    assign rd_byte = s.dev ? ((s.ptr == OMCS_CTRL_OFS) ? status :
                     diag_mem[s.ptr]) : id_mem[s.ptr]; // [RULE2] [RULE1]

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // One process computes the whole next state of the block.
    always_comb
    begin
        next_s = s;
        mem_we = 1'b0;
        next_s.scl_q = scl_i;
        next_s.sda_q = sda_i;
        next_s.pin_q = tx_disable_i;
        next_s.los = rx_signal_bad_i; // [RULE15]
        // A new fault wins over a clear in the same cycle.
        next_s.fault = (s.fault & ~pin_rise) | laser_fault_i |
                       unsafe_optical_i; // [RULE9] [RULE11] [RULE12] [RULE14]
        // The pin is assumed pulled up externally when left open.
        next_s.laser_en = ~(tx_disable_i | s.soft_dis |
                            next_s.fault); // [RULE4] [RULE5] [RULE7]
        if (start_c)
        begin
            next_s.st = S_ADDR;
            next_s.cnt = 4'h0;
            next_s.drv = 1'b0;
        end
        else if (stop_c)
        begin
            next_s.st = S_IDLE;
            next_s.drv = 1'b0;
        end
        else
        begin
            unique case (s.st)
                S_IDLE:
                begin
                    next_s.drv = 1'b0;
                end
                S_ADDR, S_RX:
                begin
                    if (scl_rise)
                    begin
                        next_s.shreg = {s.shreg[6:0], sda_i};
                        next_s.cnt = s.cnt + OMCS_CNT_STEP;
                    end
                    else if (scl_fall && s.cnt == OMCS_BYTE_BITS)
                    begin
                        next_s.st = S_ACK;
                        next_s.drv = 1'b1;
                        if (s.st == S_ADDR)
                        begin
                            next_s.dev = s.shreg[OMCS_DEV_SEL_BIT];
                            next_s.rw = s.shreg[0];
                            next_s.first = 1'b1;
                            if (!addr_hit)
                            begin
                                next_s.st = S_IDLE; // [RULE3]
                                next_s.drv = 1'b0;
                            end
                        end
                        else if (s.first)
                        begin
                            next_s.ptr = s.shreg;
                            next_s.first = 1'b0;
                        end
                        else
                        begin
                            mem_we = 1'b1;
                            next_s.ptr = s.ptr + OMCS_PTR_STEP;
                            if (s.dev && s.ptr == OMCS_CTRL_OFS) // [RULE18]
                                next_s.soft_dis = s.shreg[OMCS_SOFT_BIT];
                        end
                    end
                end
                S_ACK:
                begin
                    if (scl_fall && s.rw)
                    begin
                        next_s.st = S_TX;
                        next_s.drv = ~rd_byte[7];
                        next_s.shreg = {rd_byte[6:0], 1'b0};
                        next_s.cnt = OMCS_FIRST_BIT;
                    end
                    else if (scl_fall)
                    begin
                        next_s.st = S_RX;
                        next_s.drv = 1'b0;
                        next_s.cnt = 4'h0;
                    end
                end
                S_TX:
                begin
                    if (scl_fall && s.cnt == OMCS_BYTE_BITS)
                    begin
                        next_s.st = S_MACK;
                        next_s.drv = 1'b0;
                        next_s.ptr = s.ptr + OMCS_PTR_STEP;
                    end
                    else if (scl_fall)
                    begin
                        next_s.drv = ~s.shreg[7];
                        next_s.shreg = {s.shreg[6:0], 1'b0};
                        next_s.cnt = s.cnt + OMCS_CNT_STEP;
                    end
                end
                S_MACK:
                begin
                    if (scl_rise)
                        next_s.nack = sda_i;
                    else if (scl_fall && s.nack)
                        next_s.st = S_IDLE;
                    else if (scl_fall)
                    begin
                        next_s.st = S_TX;
                        next_s.drv = ~rd_byte[7];
                        next_s.shreg = {rd_byte[6:0], 1'b0};
                        next_s.cnt = OMCS_FIRST_BIT;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Registers and memories
    // ************************************************************
    // Reset leaves the laser off until the inputs have been sampled once.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.pin_q <= 1'b1;
        end
        else
            s <= next_s;
    end

    // Memory contents survive reset, as the module's stored data would.
    always_ff @(posedge clk_i)
    begin
        if (mem_we && s.dev)
            diag_mem[s.ptr] <= s.shreg; // [RULE2]
        else if (mem_we)
            id_mem[s.ptr] <= s.shreg; // [RULE1]
    end

    // Open-drain pins only ever pull low; the host supplies the high level.
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~s.drv;
    assign fault_o = 1'b0;
    assign fault_oe_n_o = s.fault; // [RULE10]
    assign laser_enable_o = s.laser_en;
    assign receive_signal_lost_o = s.los;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_pin_off;
        tx_disable_i |=> !laser_enable_o;
    endproperty
    a_pin_off: assert property (p_pin_off) // [RULE4]
        else $error("Pin did not stop laser.");
    property p_soft_off;
        s.soft_dis |=> !laser_enable_o;
    endproperty
    a_soft_off: assert property (p_soft_off) // [RULE7]
        else $error("Soft bit ignored.");
    property p_fault_set;
        laser_fault_i |=> fault_oe_n_o && !laser_enable_o;
    endproperty
    a_fault_set: assert property (p_fault_set) // [RULE9]
        else $error("Fault not shown.");
    // A pin rise in the same cycle is allowed to clear it in the next.
    property p_fault_hold;
        fault_oe_n_o && !pin_rise |=> fault_oe_n_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold) // [RULE11]
        else $error("Fault lost.");
    property p_fault_clr;
        pin_rise && !laser_fault_i && !unsafe_optical_i |=> !fault_oe_n_o;
    endproperty
    a_fault_clr: assert property (p_fault_clr) // [RULE12]
        else $error("Fault not cleared.");
    property p_unsafe;
        unsafe_optical_i |=> !laser_enable_o && status[OMCS_FAULT_BIT];
    endproperty
    a_unsafe: assert property (p_unsafe) // [RULE14]
        else $error("Unsafe not handled.");
    property p_los;
        !$past(rst_i) |-> receive_signal_lost_o == $past(rx_signal_bad_i);
    endproperty
    a_los: assert property (p_los) // [RULE15]
        else $error("Signal lost wrong.");
    property p_test_addr;
        s.st == S_ADDR && scl_fall && s.cnt == OMCS_BYTE_BITS &&
            s.shreg == OMCS_TEST_ADDR |=> s.st == S_IDLE && sda_oe_n_o;
    endproperty
    a_test_addr: assert property (p_test_addr) // [RULE3]
        else $error("B0 answered.");
    property p_status;
        s.dev && s.ptr == OMCS_CTRL_OFS |-> rd_byte[OMCS_PIN_BIT] ==
            tx_disable_i && rd_byte[OMCS_LOS_BIT] == receive_signal_lost_o;
    endproperty
    a_status: assert property (p_status) // [RULE8]
        else $error("Status byte wrong.");
    c_read: cover property (s.st == S_MACK);
    c_read_more: cover property (s.st == S_MACK && scl_fall && !s.nack);
    c_write: cover property (mem_we && s.dev);
    c_fault_clr: cover property (fault_oe_n_o ##1 !fault_oe_n_o);

endmodule

`default_nettype wire

/* File: tb/omcs_host_model.sv */
// Host board model: pull-ups and wire resolution for the module pins.
`timescale 1ns/1ps
`default_nettype none

module omcs_host_model
(
    input wire logic sda_low_i,
    input wire logic sda_i,
    input wire logic sda_oe_n_i,
    input wire logic fault_i,
    input wire logic fault_oe_n_i,
    input wire logic tx_en_i,
    input wire logic tx_val_i,
    output logic sda_w_o,
    output logic fault_w_o,
    output logic tx_dis_o
);
    // ************************************************************
    // Wire resolution
    // ************************************************************
    // Data line is wired-AND with a board pull-up; either side may pull.
    assign sda_w_o = !sda_low_i && (sda_oe_n_i || sda_i);
    // The fault line only reads high through the board pull-up.
    assign fault_w_o = fault_oe_n_i ? 1'b1 : fault_i;
    // An undriven transmit-off pin floats high on the module pull-up.
    assign tx_dis_o = tx_en_i ? tx_val_i : 1'b1;
endmodule

`default_nettype wire

/* File: tb/optical_module_ctrl_status_bench.sv */
// Self-checking bench for the optical module control and status logic.
`timescale 1ns/1ps
`default_nettype none

module optical_module_ctrl_status_bench;
    import omcs_pkg::*;

    // Pin spacing between transmit-off pulses, shortened to keep runs short.
    localparam int GAP_CYC = 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl = 1'b1;
    logic sda_low = 1'b0;
    logic tx_en = 1'b0;
    logic tx_val = 1'b0;
    logic laser_fault = 1'b0;
    logic unsafe = 1'b0;
    logic rx_bad = 1'b0;
    logic sda_o, sda_oe_n, fault_o, fault_oe_n, laser_en, los;
    logic sda_w, fault_w, tx_dis;
    logic ok;
    logic [7:0] rd;
    logic [7:0] rd2;
    int mismatches = 0;
    int checks = 0;

    // ************************************************************
    // Clock, device and host board
    // ************************************************************
    // Free running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    omcs_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .tx_disable_i(tx_dis), .laser_fault_i(laser_fault),
        .unsafe_optical_i(unsafe), .rx_signal_bad_i(rx_bad),
        .laser_enable_o(laser_en), .fault_o(fault_o),
        .fault_oe_n_o(fault_oe_n), .receive_signal_lost_o(los));

    omcs_host_model i_host (.sda_low_i(sda_low), .sda_i(sda_o),
        .sda_oe_n_i(sda_oe_n), .fault_i(fault_o), .fault_oe_n_i(fault_oe_n),
        .tx_en_i(tx_en), .tx_val_i(tx_val), .sda_w_o(sda_w),
        .fault_w_o(fault_w), .tx_dis_o(tx_dis));

    // ************************************************************
    // Tasks
    // ************************************************************
    // Inputs always move one nanosecond after a rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One bus bit: data set while the clock is low, sampled mid-high.
    task automatic xbit(input logic b, output logic r);
        sda_low = ~b;
        step(4);
        scl = 1'b1;
        step(2);
        r = sda_w;
        step(2);
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then the ninth bit given by mb.
    task automatic xbyte(input logic [7:0] d, input logic mb,
                         output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r[i]);
        xbit(mb, a);
        ack = ~a;
    endtask

    // Also serves as a repeated start when the clock is low.
    task automatic start;
        sda_low = 1'b0;
        step(4);
        scl = 1'b1;
        step(4);
        sda_low = 1'b1;
        step(4);
        scl = 1'b0;
    endtask

    task automatic stop;
        sda_low = 1'b1;
        step(4);
        scl = 1'b1;
        step(4);
        sda_low = 1'b0;
        step(4);
    endtask

    task automatic reg_write(input logic [7:0] dev, ofs, d);
        logic [7:0] r;
        logic a;
        start();
        xbyte(dev, 1'b1, r, a);
        xbyte(ofs, 1'b1, r, a);
        xbyte(d, 1'b1, r, a);
        stop();
    endtask

    // Pointer write, repeated start, one byte read ended by a NACK.
    task automatic reg_read(input logic [7:0] dev, ofs,
                            output logic [7:0] d, output logic ack);
        logic [7:0] r;
        logic a;
        start();
        xbyte(dev, 1'b1, r, ack);
        xbyte(ofs, 1'b1, r, a);
        start();
        xbyte(dev | 8'h01, 1'b1, r, a);
        xbyte(8'hFF, 1'b1, d, a);
        stop();
    endtask

    // Two bytes in one read: the first is acknowledged, the last is not.
    task automatic reg_read_two(input logic [7:0] dev, ofs,
                                output logic [7:0] d0, d1);
        logic [7:0] r;
        logic a;
        start();
        xbyte(dev, 1'b1, r, a);
        xbyte(ofs, 1'b1, r, a);
        start();
        xbyte(dev | 8'h01, 1'b1, r, a);
        xbyte(8'hFF, 1'b0, d0, a);
        xbyte(8'hFF, 1'b1, d1, a);
        stop();
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        step(2);
        rst_i = 1'b0;
        step(2);
        check(laser_en, 1'b0);
        tx_en = 1'b1;
        step(2);
        check(laser_en, 1'b1);
        reg_write(OMCS_ID_ADDR, 8'h10, 8'h5A);
        reg_write(OMCS_ID_ADDR, 8'h11, 8'h96);
        reg_write(OMCS_DIAG_ADDR, 8'h10, 8'hC3);
        reg_read(OMCS_ID_ADDR, 8'h10, rd, ok);
        check(rd, 8'h5A);
        check(ok, 1'b1);
        reg_read_two(OMCS_ID_ADDR, 8'h10, rd, rd2);
        check(rd, 8'h5A);
        check(rd2, 8'h96);
        reg_read(OMCS_DIAG_ADDR, 8'h10, rd, ok);
        check(rd, 8'hC3);
        reg_read(OMCS_TEST_ADDR, 8'h10, rd, ok);
        check(ok, 1'b0);
        // Software disable with the pin low; status bits ignore writes.
        reg_write(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, 8'hFF);
        step(4);
        check(laser_en, 1'b0);
        reg_read(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, rd, ok);
        check(rd, 8'h40);
        reg_write(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, 8'h00);
        step(4);
        check(laser_en, 1'b1);
        tx_val = 1'b1;
        step(2);
        check(laser_en, 1'b0);
        reg_read(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, rd, ok);
        check(rd, 8'h80);
        tx_val = 1'b0;
        rx_bad = 1'b1;
        step(2);
        check(los, 1'b1);
        reg_read(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, rd, ok);
        check(rd, 8'h02);
        rx_bad = 1'b0;
        step(2);
        check(los, 1'b0);
        // A one-cycle fault pulse must stay latched until the pin cycles.
        laser_fault = 1'b1;
        step(1);
        laser_fault = 1'b0;
        step(1);
        check({fault_w, laser_en}, 8'h02);
        step(20);
        check(fault_w, 1'b1);
        reg_read(OMCS_DIAG_ADDR, OMCS_CTRL_OFS, rd, ok);
        check(rd, 8'h04);
        step(GAP_CYC);
        tx_val = 1'b1;
        step(2);
        tx_val = 1'b0;
        step(2);
        check({fault_w, laser_en}, 8'h01);
        unsafe = 1'b1;
        step(1);
        unsafe = 1'b0;
        step(1);
        check(laser_en, 1'b0);
        step(GAP_CYC);
        tx_val = 1'b1;
        step(2);
        tx_val = 1'b0;
        step(2);
        check({fault_w, laser_en}, 8'h01);
        give_verdict();
    end

    // A hang ends the run through the same verdict as the tests.
    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
endmodule

`default_nettype wire
